// ### rtl/ppt_target.sv
`timescale 1ns/1ps

// small first-word-fall-through queue for completion beats
module ppt_fifo #(
  parameter int WIDTH = 73,
  parameter int DEPTH = ppt_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // depth must be a power of two so pointers wrap by themselves
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  // honest flags straight from the occupancy count
  assign in_ready_o  = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = store[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and count updates
  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // storage, no reset needed
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      store[wr_ptr] <= in_data_i;
    end
  end

endmodule : ppt_fifo

// programmed_io_target: single-DWORD completer behind the core's streams
module ppt_target #(
  parameter logic [7:0] IO_BAR_HIT    = ppt_pkg::IO_HIT_DEF,
  parameter logic [7:0] MEM32_BAR_HIT = ppt_pkg::MEM32_HIT_DEF,
  parameter logic [7:0] MEM64_BAR_HIT = ppt_pkg::MEM64_HIT_DEF,
  parameter logic [7:0] ROM_BAR_HIT   = ppt_pkg::ROM_HIT_DEF,
  parameter int         FIFO_DEPTH    = ppt_pkg::FIFO_DEPTH_DEF
) (
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_i,
  input  wire logic [63:0]                 rx_tdata_i,
  input  wire logic                        rx_tvalid_i,
  input  wire logic                        rx_tlast_i,
  input  wire logic [ppt_pkg::TUSER_W-1:0] rx_tuser_i,
  output logic                             rx_tready_o,
  output logic [63:0]                      tx_tdata_o,
  output logic [7:0]                       tx_tkeep_o,
  output logic                             tx_tlast_o,
  output logic                             tx_tvalid_o,
  input  wire logic                        tx_tready_i,
  input  wire logic [15:0]                 completer_id_i
);
  localparam int RAM_AW    = ppt_pkg::REGION_AW + ppt_pkg::WORD_AW;
  localparam int RAM_WORDS = 1 << RAM_AW;
  localparam int BEAT_W    = $bits(ppt_pkg::ppt_beat_type);

  ppt_pkg::ppt_state_type state;
  ppt_pkg::ppt_state_type next_state;
  ppt_pkg::ppt_state_type exec_state;
  ppt_pkg::ppt_req_type   req;
  ppt_pkg::ppt_req_type   next_req;
  ppt_pkg::ppt_beat_type  tx_q;
  ppt_pkg::ppt_beat_type  next_tx_q;
  ppt_pkg::ppt_beat_type  cpl_beat;
  ppt_pkg::ppt_beat_type  fifo_beat;
  logic                   rdy;
  logic                   next_rdy;
  logic                   tx_vld;
  logic                   next_tx_vld;
  logic                   rx_take;
  logic                   wr_en;
  logic [RAM_AW-1:0]      ram_idx;
  logic [31:0]            rd_word;
  logic [31:0]            dw0;
  logic [31:0]            dw1;
  logic [7:0]             hit;
  logic                   hdr_io;
  logic                   hdr_mem;
  logic                   hdr_ok;
  logic [1:0]             hdr_region;
  logic                   more_beats;
  logic [31:0]            cpl_dw0;
  logic [31:0]            cpl_dw1;
  logic [31:0]            cpl_dw2;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  logic                   fifo_out_ready;

  // a completion is two beats, so the queue must hold at least two
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("completion fifo needs at least two entries");
  end
  if ($countones(IO_BAR_HIT) > 1 || $countones(MEM32_BAR_HIT) > 1 ||
      $countones(MEM64_BAR_HIT) > 1 || $countones(ROM_BAR_HIT) > 1) begin : g_bad_hit
    $error("each region answers to at most one BAR");
  end

  // byte count of a one-DWORD access from its enables
  function automatic logic [11:0] f_byte_count(input logic [3:0] be);
    casez (be)
      4'b1??1:                  f_byte_count = 12'h004;
      4'b01?1, 4'b1?10:         f_byte_count = 12'h003;
      4'b0011, 4'b0110, 4'b1100: f_byte_count = 12'h002;
      default:                  f_byte_count = 12'h001;
    endcase
  endfunction : f_byte_count

  // offset of the first enabled byte
  function automatic logic [1:0] f_low_addr(input logic [3:0] be);
    casez (be)
      4'b??10: f_low_addr = 2'h1;
      4'b?100: f_low_addr = 2'h2;
      4'b1000: f_low_addr = 2'h3;
      default: f_low_addr = 2'h0;
    endcase
  endfunction : f_low_addr

  // header words and BAR hit vector of the current beat
  assign dw0     = rx_tdata_i[31:0];
  assign dw1     = rx_tdata_i[63:32];
  assign hit     = rx_tuser_i[ppt_pkg::HIT_LSB +: ppt_pkg::HIT_W];
  assign rx_take = rx_tvalid_i & rdy;
  assign wr_en   = (state == ppt_pkg::ST_WRITE);
  assign ram_idx = {req.region, req.addr};

  // region steering from the header type and format, and for 3DW memory from the hit vector, never from the address
  always_comb begin
    hdr_io     = (dw0[28:24] == ppt_pkg::TYPE_IO) && !dw0[29];
    hdr_mem    = (dw0[28:24] == ppt_pkg::TYPE_MEM);
    hdr_ok     = 1'b0;
    hdr_region = ppt_pkg::REGION_MEM32;
    if (hdr_io) begin
      hdr_region = ppt_pkg::REGION_IO;
      hdr_ok     = (IO_BAR_HIT != '0) && (hit == IO_BAR_HIT);
    end else if (hdr_mem && dw0[29]) begin
      hdr_region = ppt_pkg::REGION_MEM64;
      hdr_ok     = (MEM64_BAR_HIT != '0) && (hit == MEM64_BAR_HIT);
    end else if (hdr_mem && ROM_BAR_HIT != '0 && hit == ROM_BAR_HIT) begin
      hdr_region = ppt_pkg::REGION_ROM;
      hdr_ok     = 1'b1;
    end else if (hdr_mem) begin
      hdr_ok     = (MEM32_BAR_HIT != '0) && (hit == MEM32_BAR_HIT);
    end
  end

  // action once the header is complete; unmatched requests vanish
  assign exec_state = !req.ok   ? ppt_pkg::ST_IDLE :
                      req.write ? ppt_pkg::ST_WRITE : ppt_pkg::ST_READ;
  assign more_beats = req.fmt_4dw & req.write;

  // receive state machine and captured request
  always_comb begin
    next_state = state;
    next_req   = req;
    unique case (state)
      ppt_pkg::ST_IDLE: begin
        if (rx_take) begin
          next_req.fmt_4dw = dw0[29];
          next_req.write   = dw0[30];
          next_req.io      = hdr_io;
          next_req.tc      = dw0[22:20];
          next_req.attr    = dw0[13:12];
          next_req.rid     = dw1[31:16];
          next_req.tag     = dw1[15:8];
          next_req.be      = dw1[3:0];
          next_req.region  = hdr_region;
          next_req.ok      = hdr_ok;
          if (rx_tlast_i) begin
            next_state = ppt_pkg::ST_IDLE;
          end else if ((hdr_io || hdr_mem) && dw0[9:0] == ppt_pkg::LEN_ONE) begin
            next_state = ppt_pkg::ST_HDR;
          end else begin
            next_state = ppt_pkg::ST_DRAIN;
          end
        end
      end
      ppt_pkg::ST_HDR: begin
        if (rx_take) begin
          // low address bits only, so wide apertures wrap
          next_req.addr = req.fmt_4dw ? dw1[10:2] : dw0[10:2];
          next_req.data = dw1;
          if (rx_tlast_i) begin
            next_state = more_beats ? ppt_pkg::ST_IDLE : exec_state;
          end else begin
            next_state = more_beats ? ppt_pkg::ST_DATA : ppt_pkg::ST_DRAIN;
          end
        end
      end
      ppt_pkg::ST_DATA: begin
        if (rx_take) begin
          next_req.data = dw0;
          next_state    = rx_tlast_i ? exec_state : ppt_pkg::ST_DRAIN;
        end
      end
      ppt_pkg::ST_DRAIN: begin
        if (rx_take && rx_tlast_i) begin
          next_state = ppt_pkg::ST_IDLE;
        end
      end
      ppt_pkg::ST_WRITE: begin
        next_state = req.io ? ppt_pkg::ST_CPL0 : ppt_pkg::ST_IDLE;
      end
      ppt_pkg::ST_READ: begin
        next_state = ppt_pkg::ST_CPL0;
      end
      ppt_pkg::ST_CPL0: begin
        if (fifo_in_ready) begin
          next_state = ppt_pkg::ST_CPL1;
        end
      end
      ppt_pkg::ST_CPL1: begin
        if (fifo_in_ready) begin
          next_state = ppt_pkg::ST_IDLE;
        end
      end
    endcase
    // stall the stream during RAM access and completion building
    next_rdy = next_state inside {ppt_pkg::ST_IDLE, ppt_pkg::ST_HDR,
                                  ppt_pkg::ST_DATA, ppt_pkg::ST_DRAIN};
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ppt_pkg::ST_IDLE;
      req   <= '0;
      rdy   <= ppt_pkg::RDY_RST;
    end else begin
      state <= next_state;
      req   <= next_req;
      rdy   <= next_rdy;
    end
  end

  assign rx_tready_o = rdy;

  // four regions as one array, one lane per byte
  for (genvar g = 0; g < 4; g++) begin : g_lane
    logic [7:0] lane_ram [0:RAM_WORDS-1];
    logic [7:0] lane_q;
    always_ff @(posedge sys_clk_i) begin
      if (wr_en && req.be[g]) begin
        lane_ram[ram_idx] <= req.data[8*g +: 8];
      end
      lane_q <= lane_ram[ram_idx];
    end
    assign rd_word[8*g +: 8] = lane_q;
  end

  // completion header words, echoing the request's identity
  assign cpl_dw0 = {1'b0, req.write ? ppt_pkg::FMT_NODATA : ppt_pkg::FMT_DATA,
                    ppt_pkg::TYPE_CPL, 1'b0, req.tc, 4'h0, 2'h0, req.attr, 2'h0,
                    req.write ? ppt_pkg::LEN_NONE : ppt_pkg::LEN_ONE};
  assign cpl_dw1 = {completer_id_i, ppt_pkg::CPL_OK, 1'b0, f_byte_count(req.be)};
  assign cpl_dw2 = {req.rid, req.tag, 1'b0, req.addr[4:0], f_low_addr(req.be)};

  // beat pushed into the completion queue
  always_comb begin
    if (state == ppt_pkg::ST_CPL0) begin
      cpl_beat.data = {cpl_dw1, cpl_dw0};
      cpl_beat.keep = ppt_pkg::KEEP_ALL;
      cpl_beat.last = 1'b0;
    end else begin
      cpl_beat.data = {req.write ? ppt_pkg::NO_DATA : rd_word, cpl_dw2};
      cpl_beat.keep = req.write ? ppt_pkg::KEEP_LOW : ppt_pkg::KEEP_ALL;
      cpl_beat.last = 1'b1;
    end
  end

  assign fifo_in_valid = state inside {ppt_pkg::ST_CPL0, ppt_pkg::ST_CPL1};

  ppt_fifo #(
    .WIDTH(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cpl_fifo (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .in_valid_i (fifo_in_valid),
    .in_data_i  (cpl_beat),
    .in_ready_o (fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o (fifo_beat),
    .out_ready_i(fifo_out_ready)
  );

  // registered transmit stage, held while the core stalls
  always_comb begin
    fifo_out_ready = !tx_vld || tx_tready_i;
    next_tx_vld    = fifo_out_ready ? fifo_out_valid : tx_vld;
    next_tx_q      = (fifo_out_ready && fifo_out_valid) ? fifo_beat : tx_q;
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      tx_vld <= 1'b0;
      tx_q   <= '0;
    end else begin
      tx_vld <= next_tx_vld;
      tx_q   <= next_tx_q;
    end
  end

  assign tx_tvalid_o = tx_vld;
  assign tx_tdata_o  = tx_q.data;
  assign tx_tkeep_o  = tx_q.keep;
  assign tx_tlast_o  = tx_q.last;

  // checks on the receive and completion behaviour
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  property p_write_stall;
    (state == ppt_pkg::ST_WRITE) |-> !rx_tready_o;
  endproperty
  a_write_stall: assert property (p_write_stall)
    else $error("ready high during ram write");

  property p_read_stall;
    (state == ppt_pkg::ST_READ) |=> (state == ppt_pkg::ST_CPL0) && !rx_tready_o;
  endproperty
  a_read_stall: assert property (p_read_stall)
    else $error("read not held off until completion");

  property p_read_cpl;
    (state == ppt_pkg::ST_READ) |=> fifo_in_valid && cpl_beat.data[30]
      && (cpl_beat.data[9:0] == ppt_pkg::LEN_ONE);
  endproperty
  a_read_cpl: assert property (p_read_cpl)
    else $error("read not answered with one dword");

  property p_io_write_cpl;
    (state == ppt_pkg::ST_WRITE && req.io) |=> (state == ppt_pkg::ST_CPL0)
      && !cpl_beat.data[30] && (cpl_beat.data[47:45] == ppt_pkg::CPL_OK);
  endproperty
  a_io_write_cpl: assert property (p_io_write_cpl)
    else $error("io write lacks good completion");

  property p_mem_write_quiet;
    (state == ppt_pkg::ST_WRITE && !req.io)
      |=> ((state == ppt_pkg::ST_IDLE) && !fifo_in_valid) ##1 !fifo_in_valid;
  endproperty
  a_mem_write_quiet: assert property (p_mem_write_quiet)
    else $error("memory write produced a completion");

  property p_long_drop;
    (state == ppt_pkg::ST_IDLE && rx_take && !rx_tlast_i
      && dw0[9:0] != ppt_pkg::LEN_ONE) |=> (state == ppt_pkg::ST_DRAIN);
  endproperty
  a_long_drop: assert property (p_long_drop)
    else $error("long request not drained");

  property p_no_hit_drop;
    (state == ppt_pkg::ST_HDR && rx_take && rx_tlast_i && !more_beats && !req.ok)
      |=> (state == ppt_pkg::ST_IDLE) && !wr_en;
  endproperty
  a_no_hit_drop: assert property (p_no_hit_drop)
    else $error("unmatched request was served");

  property p_echo;
    (state == ppt_pkg::ST_CPL1) |-> (cpl_beat.data[31:16] == req.rid)
      && (cpl_beat.data[15:8] == req.tag) && cpl_beat.last;
  endproperty
  a_echo: assert property (p_echo)
    else $error("completion does not echo request");

  property p_rom_steer;
    (state == ppt_pkg::ST_IDLE && rx_take && hdr_mem && !dw0[29]
      && ROM_BAR_HIT != '0 && hit == ROM_BAR_HIT)
      |=> (req.region == ppt_pkg::REGION_ROM) && req.ok;
  endproperty
  a_rom_steer: assert property (p_rom_steer)
    else $error("rom access not steered to rom region");

endmodule : ppt_target

// ### rtl/ppt_pkg.sv
package ppt_pkg;

  // receive sideband layout
  localparam int          TUSER_W        = 22;
  localparam int          HIT_LSB        = 2;
  localparam int          HIT_W          = 8;

  // storage shape: 512 words of 4 bytes per region, four regions
  localparam int          WORD_AW        = 9;
  localparam int          REGION_AW      = 2;
  localparam logic [1:0]  REGION_IO      = 2'h0;  // io_region_ram
  localparam logic [1:0]  REGION_MEM32   = 2'h1;  // mem32_region_ram
  localparam logic [1:0]  REGION_MEM64   = 2'h2;  // mem64_region_ram
  localparam logic [1:0]  REGION_ROM     = 2'h3;  // rom_region_ram

  // default BAR hit vectors, zero means no BAR enabled
  localparam logic [7:0]  IO_HIT_DEF     = 8'h00;
  localparam logic [7:0]  MEM32_HIT_DEF  = 8'h01;
  localparam logic [7:0]  MEM64_HIT_DEF  = 8'h00;
  localparam logic [7:0]  ROM_HIT_DEF    = 8'h40;  // expansion_rom_space

  // packet header codes
  localparam logic [4:0]  TYPE_MEM       = 5'h00;
  localparam logic [4:0]  TYPE_IO        = 5'h02;
  localparam logic [4:0]  TYPE_CPL       = 5'h0A;
  localparam logic [1:0]  FMT_NODATA     = 2'h0;
  localparam logic [1:0]  FMT_DATA       = 2'h2;
  localparam logic [9:0]  LEN_ONE        = 10'h001;
  localparam logic [9:0]  LEN_NONE       = 10'h000;
  localparam logic [2:0]  CPL_OK         = 3'h0;
  localparam logic [7:0]  KEEP_ALL       = 8'hFF;
  localparam logic [7:0]  KEEP_LOW       = 8'h0F;
  localparam logic [31:0] NO_DATA        = 32'h0000_0000;

  // reset values and depths
  localparam logic        RDY_RST        = 1'b1;
  localparam int          FIFO_DEPTH_DEF = 8;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_HDR   = 8'h02,
    ST_DATA  = 8'h04,
    ST_DRAIN = 8'h08,
    ST_WRITE = 8'h10,
    ST_READ  = 8'h20,
    ST_CPL0  = 8'h40,
    ST_CPL1  = 8'h80
  } ppt_state_type;

  typedef struct packed {
    logic                 fmt_4dw;
    logic                 write;
    logic                 io;
    logic [2:0]           tc;
    logic [1:0]           attr;
    logic [15:0]          rid;
    logic [7:0]           tag;
    logic [3:0]           be;
    logic [REGION_AW-1:0] region;
    logic                 ok;
    logic [WORD_AW-1:0]   addr;
    logic [31:0]          data;
  } ppt_req_type;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic        last;
  } ppt_beat_type;

endpackage : ppt_pkg

// ### sim/ppt_core_model.sv
`timescale 1ns/1ps

// core side: offers receive packets, sinks completion beats
module ppt_core_model (
  input  wire logic                        sys_clk_i,
  output logic [63:0]                      rx_tdata_o,
  output logic                             rx_tvalid_o,
  output logic                             rx_tlast_o,
  output logic [ppt_pkg::TUSER_W-1:0]      rx_tuser_o,
  input  wire logic                        rx_tready_i,
  input  wire logic [63:0]                 tx_tdata_i,
  input  wire logic [7:0]                  tx_tkeep_i,
  input  wire logic                        tx_tlast_i,
  input  wire logic                        tx_tvalid_i,
  output logic                             tx_tready_o,
  input  wire logic                        stall_i,
  input  wire logic                        slow_i
);
  logic                        phase;
  ppt_pkg::ppt_beat_type       q [$];

  // idle receive lines at time zero
  initial begin
    rx_tdata_o = 64'h0000_0000_0000_0000;
    rx_tvalid_o = 1'b0;
    rx_tlast_o = 1'b0;
    rx_tuser_o = '0;
    phase = 1'b0;
  end

  // ready either prompt, every other cycle, or withheld
  always @(posedge sys_clk_i) phase <= ~phase;
  assign tx_tready_o = !stall_i && (!slow_i || phase);

  // collect every accepted completion beat
  always @(posedge sys_clk_i) begin
    if (tx_tvalid_i && tx_tready_o) begin
      q.push_back(ppt_pkg::ppt_beat_type'{tx_tdata_i, tx_tkeep_i, tx_tlast_i});
    end
  end

  // one packet: beats held until ready sampled high, hit vector alongside
  task automatic send(input logic [63:0] b [3], input int n, input logic [7:0] hit);
    logic rdy;
    int   i;
    int   w;
    @(posedge sys_clk_i);
    #1;
    for (i = 0; i < n; i++) begin
      rx_tdata_o = b[i];
      rx_tvalid_o = 1'b1;
      rx_tlast_o = (i == n - 1);
      rx_tuser_o = 22'(hit) << 2;
      rdy = 1'b0;
      // ready moves only on edges, so its value now is what the next edge sees
      for (w = 0; w < 400 && !rdy; w++) begin
        rdy = rx_tready_i;
        @(posedge sys_clk_i);
        #1;
      end
    end
    // released lines show the inverse, never the stale beat
    rx_tvalid_o = 1'b0;
    rx_tlast_o = 1'b0;
    rx_tdata_o = ~rx_tdata_o;
    rx_tuser_o = ~rx_tuser_o;
  endtask : send
endmodule : ppt_core_model

// ### sim/ppt_target_bench.sv
`timescale 1ns/1ps

// self-checking bench for the single-dword completer
module ppt_target_bench;
  localparam logic [7:0]  IO_HIT  = 8'h20;
  localparam logic [7:0]  M64_HIT = 8'h04;
  localparam logic [15:0] CID     = 16'hA5C3;
  localparam logic [15:0] RID     = 16'h1234;
  logic                        sys_clk_i, reset_i, stall, slow;
  logic [63:0]                 rx_tdata, tx_tdata;
  logic [ppt_pkg::TUSER_W-1:0] rx_tuser;
  logic [7:0]                  tx_tkeep;
  logic                        rx_tvalid, rx_tlast, rx_tready, tx_tlast, tx_tvalid, tx_tready;
  int                          n_errors, n_checks;

  ppt_target #(.IO_BAR_HIT(IO_HIT), .MEM64_BAR_HIT(M64_HIT)) ppt_target_i (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .rx_tdata_i(rx_tdata),
    .rx_tvalid_i(rx_tvalid), .rx_tlast_i(rx_tlast), .rx_tuser_i(rx_tuser),
    .rx_tready_o(rx_tready), .tx_tdata_o(tx_tdata), .tx_tkeep_o(tx_tkeep),
    .tx_tlast_o(tx_tlast), .tx_tvalid_o(tx_tvalid), .tx_tready_i(tx_tready),
    .completer_id_i(CID));

  ppt_core_model ppt_core_model_i (
    .sys_clk_i(sys_clk_i), .rx_tdata_o(rx_tdata), .rx_tvalid_o(rx_tvalid),
    .rx_tlast_o(rx_tlast), .rx_tuser_o(rx_tuser), .rx_tready_i(rx_tready),
    .tx_tdata_i(tx_tdata), .tx_tkeep_i(tx_tkeep), .tx_tlast_i(tx_tlast),
    .tx_tvalid_i(tx_tvalid), .tx_tready_o(tx_tready), .stall_i(stall), .slow_i(slow));

  // 25 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task automatic report_and_stop;
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_beat(input ppt_pkg::ppt_beat_type got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t beat %h expected %h", $time, got, exp);
    end
  endtask : check_beat

  task automatic check_flag(input logic got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : check_flag

  // build and offer one request packet
  task automatic req(input logic wr, io, w64, input logic [7:0] hit, input logic [31:0] a, d,
                     input logic [3:0] be, input logic [9:0] len, input logic [7:0] tag);
    logic [63:0] b [3];
    logic [31:0] h0;
    h0 = {1'b0, wr, w64, io ? ppt_pkg::TYPE_IO : ppt_pkg::TYPE_MEM, 1'b0, 3'h5, 4'h0,
          2'b00, 2'h2, 2'b00, len};
    b[0] = {RID, tag, 4'h0, be, h0};
    b[1] = w64 ? {a, 32'h0000_0000} : {d, a};
    b[2] = w64 ? {32'h0000_0000, d} : {~d, ~d};
    ppt_core_model_i.send(b, 2 + int'(w64 && wr) + int'(wr && len == 10'h002), hit);
  endtask : req

  // wait for two beats and compare them with the expected completion
  task automatic expect_cpl(input logic wd, input logic [7:0] tag, input logic [31:0] a, d);
    ppt_pkg::ppt_beat_type e0, e1;
    for (int i = 0; i < 400 && ppt_core_model_i.q.size() < 2; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    if (ppt_core_model_i.q.size() < 2) begin
      n_errors++;
      $display("[FAIL] %0t completion missing", $time);
      return;
    end
    e0.data = {CID, ppt_pkg::CPL_OK, 1'b0, 12'h004, 1'b0, wd, 1'b0, ppt_pkg::TYPE_CPL, 1'b0,
               3'h5, 4'h0, 2'b00, 2'h2, 2'b00, wd ? ppt_pkg::LEN_ONE : ppt_pkg::LEN_NONE};
    e0.keep = ppt_pkg::KEEP_ALL;
    e0.last = 1'b0;
    e1.data = {wd ? d : ppt_pkg::NO_DATA, RID, tag, 1'b0, a[6:2], 2'b00};
    e1.keep = wd ? ppt_pkg::KEEP_ALL : ppt_pkg::KEEP_LOW;
    e1.last = 1'b1;
    check_beat(ppt_core_model_i.q.pop_front(), e0);
    check_beat(ppt_core_model_i.q.pop_front(), e1);
  endtask : expect_cpl

  task automatic expect_none;
    repeat (40) @(posedge sys_clk_i);
    #1;
    check_flag(ppt_core_model_i.q.size() == 0, 1'b1);
  endtask : expect_none

  task automatic wr(input logic io, w64, input logic [7:0] hit, input logic [31:0] a, d,
                    input logic [3:0] be);
    req(1'b1, io, w64, hit, a, d, be, ppt_pkg::LEN_ONE, 8'h00);
    check_flag(rx_tready, 1'b0);
    if (io) expect_cpl(1'b0, 8'h00, a, 32'h0000_0000);
  endtask : wr

  task automatic rd(input logic io, w64, input logic [7:0] hit, input logic [31:0] a, d,
                    input logic [7:0] tag);
    req(1'b0, io, w64, hit, a, 32'h0000_0000, 4'hF, ppt_pkg::LEN_ONE, tag);
    check_flag(rx_tready, 1'b0);
    expect_cpl(1'b1, tag, a, d);
  endtask : rd

  // each region keeps its own word; wider apertures wrap
  task automatic t_regions;
    wr(0, 0, 8'h01, 32'h0000_0010, 32'h1111_2222, 4'hF);
    wr(0, 0, 8'h40, 32'h0000_0010, 32'h3333_4444, 4'hF);
    wr(1, 0, IO_HIT, 32'h0000_0080, 32'h5555_6666, 4'hF);
    wr(0, 1, M64_HIT, 32'h0000_0810, 32'h7777_8888, 4'hF);
    rd(0, 0, 8'h01, 32'h0000_0010, 32'h1111_2222, 8'h11);
    rd(0, 0, 8'h40, 32'h0000_0010, 32'h3333_4444, 8'h12);
    rd(1, 0, IO_HIT, 32'h0000_0080, 32'h5555_6666, 8'h13);
    rd(0, 1, M64_HIT, 32'h0000_0010, 32'h7777_8888, 8'h14);
    rd(0, 1, M64_HIT, 32'h0000_1010, 32'h7777_8888, 8'h15);
  endtask : t_regions

  // partial byte enables merge into the old word
  task automatic t_bytes;
    wr(0, 0, 8'h01, 32'h0000_0020, 32'hAABB_CCDD, 4'hF);
    wr(0, 0, 8'h01, 32'h0000_0020, 32'h1122_3344, 4'h5);
    rd(0, 0, 8'h01, 32'h0000_0020, 32'hAA22_CC44, 8'h16);
  endtask : t_bytes

  // long requests and unserved BARs change nothing and get no answer
  task automatic t_drop;
    req(1, 0, 0, 8'h01, 32'h0000_0010, 32'hDEAD_0000, 4'hF, 10'h002, 8'h00);
    expect_none();
    req(0, 0, 0, 8'h01, 32'h0000_0010, 32'h0000_0000, 4'hF, 10'h002, 8'h20);
    expect_none();
    req(0, 0, 0, 8'h02, 32'h0000_0010, 32'h0000_0000, 4'hF, ppt_pkg::LEN_ONE, 8'h21);
    expect_none();
    req(1, 0, 0, 8'h02, 32'h0000_0010, 32'hBAD0_BAD0, 4'hF, ppt_pkg::LEN_ONE, 8'h00);
    expect_none();
    rd(0, 0, 8'h01, 32'h0000_0010, 32'h1111_2222, 8'h22);
  endtask : t_drop

  // stalled sink fills the completion queue until receive refuses
  task automatic t_fill;
    stall = 1'b1;
    for (int k = 0; k < 5; k++) begin
      req(0, 0, 0, 8'h01, 32'h0000_0010, 32'h0000_0000, 4'hF, ppt_pkg::LEN_ONE,
          8'(8'h30 + k));
    end
    repeat (20) @(posedge sys_clk_i);
    #1;
    check_flag(rx_tready, 1'b0);
    check_flag(ppt_core_model_i.q.size() == 0, 1'b1);
    slow = 1'b1;
    stall = 1'b0;
    for (int k = 0; k < 5; k++) begin
      expect_cpl(1'b1, 8'(8'h30 + k), 32'h0000_0010, 32'h1111_2222);
    end
    rd(0, 0, 8'h40, 32'h0000_0010, 32'h3333_4444, 8'h40);
    slow = 1'b0;
  endtask : t_fill

  // main sequence
  initial begin
    reset_i = 1'b1;
    stall = 1'b0;
    slow = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (20) @(posedge sys_clk_i);
    #1;
    reset_i = 1'b0;
    check_flag(rx_tready, ppt_pkg::RDY_RST);
    check_flag(tx_tvalid, 1'b0);
    t_regions();
    t_bytes();
    t_drop();
    t_fill();
    report_and_stop();
  end

  // watchdog: the sequence needs a few thousand cycles at most
  initial begin
    #(40 * 30000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule : ppt_target_bench
